// file: rtl/msd_pkg.sv
// Purpose: Constants for the memory space decoder and external cycle sequencer
// Assumes: 100 MHz sys_clk, byte-wide external data port
// Notes:   Address map and external cycle phase lengths
// Notes on behaviour
// R01 - Program 0..7FFFh goes to on-chip program memory
// R02 - Data 0..04FFh goes to on-chip RAM
// R03 - Fetches above 32K run external cycles
// R04 - Data strobe stays high for on-chip cycles
// R05 - Space select driven on each external cycle
// R06 - Unpaged spaces are 64K, 16-bit address
// R07 - Paging extends upper 32K to 8M
// R08 - OTP variant reserves top 64 program bytes
// R09 - Off-chip address on three ports
// R10 - Address strobe pulses once per cycle start
// R11 - Direction low only for external writes
// R12 - Write data driven with strobe; read data sampled
// R13 - Data above RAM goes external, select shows data
package msd_pkg;
  localparam logic [15:0] PROG_ONCHIP_TOP = 16'h7FFF;
  localparam logic [15:0] DATA_RAM_TOP    = 16'h04FF;
  localparam logic [15:0] OTP_RSV_BASE    = 16'hFFC0;
  localparam int          ADDR_W          = 16;
  localparam int          BANK_W          = 8;
  // Phase lengths in sys_clk cycles
  localparam logic [3:0]  AS_LOW_CYC      = 4'h2;
  localparam logic [3:0]  AS_HOLD_CYC     = 4'h1;
  localparam logic [3:0]  DS_LOW_CYC      = 4'h3;
  localparam logic [3:0]  END_CYC         = 4'h1;
  typedef enum logic [2:0] {
    MSD_IDLE  = 3'b000,
    MSD_ASLOW = 3'b001,
    MSD_AHOLD = 3'b010,
    MSD_DSLOW = 3'b011,
    MSD_END   = 3'b100,
    MSD_INT   = 3'b101
  } msd_state_type;
endpackage : msd_pkg

// file: rtl/msd_decoder.sv
// Purpose: Steers core memory requests on-chip or to an external bus cycle
// Assumes: One request at a time, held until done pulses; ext_rdata is async
// Notes:   All outputs registered; one clock domain
`timescale 1ns/1ps
module msd_decoder #(
  parameter bit OTP_VARIANT = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        req,
  input  wire logic        req_prog,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  input  wire logic        bank_en,
  input  wire logic [7:0]  bank_sel,
  input  wire logic [7:0]  ext_rdata,
  output logic             done,
  output logic             reserved_err,
  output logic [7:0]       rdata,
  output logic             sel_prog_rom,
  output logic             sel_data_ram,
  output logic             address_strobe_n,
  output logic             data_strobe_n,
  output logic             rd_wr_n,
  output logic             prog_data_sel,
  output logic [7:0]       ad_out,
  output logic             ad_oe,
  output logic [7:0]       addr_hi,
  output logic [7:0]       addr_lo,
  output logic [7:0]       bank_addr
);
  typedef struct packed {
    msd_pkg::msd_state_type st;
    logic [3:0] cnt;
    logic       done;
    logic       rsv;
    logic [7:0] rdata;
    logic       rom;
    logic       ram;
    logic       as_n;
    logic       ds_n;
    logic       rw;
    logic       pd;
    logic [7:0] ad;
    logic       ad_oe;
    logic [7:0] ahi;
    logic [7:0] alo;
    logic [7:0] bank;
    logic [7:0] wdat;
    logic       wr;
  } msd_regs_type;

  msd_regs_type q, d;
  logic [7:0] rd_s1, rd_s2;
  logic       is_int, is_rsv;

  // Read data port from pins passes two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_s1 <= 8'h00;
      rd_s2 <= 8'h00;
    end else begin
      rd_s1 <= ext_rdata;
      rd_s2 <= rd_s1;
    end
  end

  // Space decode of the incoming request
  always_comb begin
    if (req_prog) begin
      is_int = (req_addr <= msd_pkg::PROG_ONCHIP_TOP); // R01 R03
      is_rsv = OTP_VARIANT && (req_addr >= msd_pkg::OTP_RSV_BASE); // R08
    end else begin
      is_int = (req_addr <= msd_pkg::DATA_RAM_TOP); // R02 R13
      is_rsv = 1'b0;
    end
  end

  // Cycle sequencer
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.rsv  = 1'b0;
    d.cnt  = (q.cnt != 4'h0) ? q.cnt - 4'h1 : 4'h0;
    case (q.st)
      msd_pkg::MSD_IDLE: begin
        d.rw    = 1'b1;
        d.ad_oe = 1'b0;
        if (req) begin
          d.ahi  = req_addr[15:8]; // R06 R09
          d.alo  = req_addr[7:0]; // R09
          d.ad   = req_addr[7:0];
          d.ad_oe = 1'b1;
          d.pd   = req_prog; // R05 R13
          d.wr   = req_write;
          d.wdat = req_wdata;
          // Upper half is paged only when paging is on
          d.bank = (bank_en && req_addr[15]) ? bank_sel : 8'h00; // R07
          d.rom  = is_int && req_prog;
          d.ram  = is_int && !req_prog;
          d.rw   = !(req_write && !is_int); // R11
          d.as_n = 1'b0; // R10
          d.cnt  = msd_pkg::AS_LOW_CYC - 4'h1;
          d.st   = is_rsv ? msd_pkg::MSD_END : msd_pkg::MSD_ASLOW;
          // Reserved marker rides in the counter so the flag pulses with done
          if (is_rsv) begin
            d.cnt   = '1; // R08
            d.as_n  = 1'b1;
            d.ad_oe = 1'b0;
            d.rw    = 1'b1;
          end
        end
      end
      msd_pkg::MSD_ASLOW: begin
        if (q.cnt == 4'h0) begin
          d.as_n = 1'b1; // R10
          d.cnt  = msd_pkg::AS_HOLD_CYC - 4'h1;
          d.st   = msd_pkg::MSD_AHOLD;
        end
      end
      msd_pkg::MSD_AHOLD: begin
        if (q.cnt == 4'h0) begin
          d.cnt = msd_pkg::DS_LOW_CYC - 4'h1;
          if (q.rom || q.ram) begin
            d.st = msd_pkg::MSD_INT; // R04
          end else begin
            d.ds_n  = 1'b0; // R12
            d.ad    = q.wdat; // R12
            d.ad_oe = q.wr;
            d.st    = msd_pkg::MSD_DSLOW;
          end
        end
      end
      msd_pkg::MSD_DSLOW: begin
        if (q.cnt == 4'h0) begin
          d.ds_n  = 1'b1;
          d.rdata = q.wr ? 8'h00 : rd_s2; // R12
          d.cnt   = msd_pkg::END_CYC - 4'h1;
          d.st    = msd_pkg::MSD_END;
        end
      end
      msd_pkg::MSD_INT: begin
        d.ds_n = 1'b1; // R04
        if (q.cnt == 4'h0) begin
          d.st = msd_pkg::MSD_END;
        end
      end
      msd_pkg::MSD_END: begin
        d.ad_oe = 1'b0;
        d.rw    = 1'b1;
        d.rom   = 1'b0;
        d.ram   = 1'b0;
        d.done  = 1'b1;
        d.rsv   = (q.cnt != 4'h0); // R08
        d.st    = msd_pkg::MSD_IDLE;
      end
      default: d.st = msd_pkg::MSD_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q      <= '0;
      q.as_n <= 1'b1;
      q.ds_n <= 1'b1;
      q.rw   <= 1'b1;
      q.st   <= msd_pkg::MSD_IDLE;
    end else begin
      q <= d;
    end
  end

  assign done             = q.done;
  assign reserved_err     = q.rsv;
  assign rdata            = q.rdata;
  assign sel_prog_rom     = q.rom;
  assign sel_data_ram     = q.ram;
  assign address_strobe_n = q.as_n;
  assign data_strobe_n    = q.ds_n;
  assign rd_wr_n          = q.rw;
  assign prog_data_sel    = q.pd;
  assign ad_out           = q.ad;
  assign ad_oe            = q.ad_oe;
  assign addr_hi          = q.ahi;
  assign addr_lo          = q.alo;
  assign bank_addr        = q.bank;
endmodule : msd_decoder

// file: test/msd_checker.sv
// Purpose: Timing and steering checks on the decoder's ports
// Assumes: Phase lengths 2/1/3/1 cycles
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module msd_checker (
  input wire logic       sys_clk, nrst, bank_en, done, sel_prog_rom, sel_data_ram,
  input wire logic       address_strobe_n, data_strobe_n, rd_wr_n, prog_data_sel, ad_oe,
  input wire logic [7:0] req_wdata, bank_sel, ad_out, addr_hi, addr_lo, bank_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Strobe shapes and cycle length
  property p_as; $fell(address_strobe_n) |-> ##2 $rose(address_strobe_n); endproperty
  a_as: assert property (p_as) else $error("as pulse");
  property p_len; $fell(address_strobe_n) |-> ##7 done; endproperty
  a_len: assert property (p_len) else $error("cycle len");
  property p_ds; $fell(data_strobe_n) |-> !data_strobe_n[*3] ##1 data_strobe_n ##1 done;
  endproperty
  a_ds: assert property (p_ds) else $error("ds pulse");
  property p_onc; (sel_prog_rom || sel_data_ram) |-> data_strobe_n; endproperty
  a_onc: assert property (p_onc) else $error("ds on-chip");
  property p_dir; !rd_wr_n |-> !(sel_prog_rom || sel_data_ram); endproperty
  a_dir: assert property (p_dir) else $error("direction");
  // Address map and write data
  property p_rom; sel_prog_rom |-> prog_data_sel && !addr_hi[7]; endproperty
  a_rom: assert property (p_rom) else $error("rom map");
  property p_ram; sel_data_ram |-> !prog_data_sel && {addr_hi, addr_lo} <= 16'h04FF;
  endproperty
  a_ram: assert property (p_ram) else $error("ram map");
  property p_ext; $fell(data_strobe_n) |-> (prog_data_sel ? addr_hi[7]
    : {addr_hi, addr_lo} > 16'h04FF); endproperty
  a_ext: assert property (p_ext) else $error("ext steer");
  property p_wr; !data_strobe_n && !rd_wr_n |-> ad_oe && ad_out == req_wdata; endproperty
  a_wr: assert property (p_wr) else $error("write data");
  property p_bank; $fell(address_strobe_n) |->
    bank_addr == ((bank_en && addr_hi[7]) ? bank_sel : 8'h00); endproperty
  a_bank: assert property (p_bank) else $error("bank");
endmodule : msd_checker

// file: test/msd_ext_mem.sv
// Purpose: Off-chip memory split by the space select line
// Assumes: Key is space select plus low address port
// Notes:   Read bus toggles when not driven
`timescale 1ns/1ps
module msd_ext_mem (
  input  wire logic       sys_clk, data_strobe_n, rd_wr_n, prog_data_sel,
  input  wire logic [7:0] addr_lo, ad_out,
  output logic      [7:0] ext_rdata
);
  logic [7:0] mem [512];
  // Store on write strobe, space picks bank of array
  always @(posedge sys_clk) if (!data_strobe_n && !rd_wr_n) mem[{prog_data_sel, addr_lo}] <= ad_out;
  // Drive only in read strobe, else changing pattern
  assign ext_rdata = (!data_strobe_n && rd_wr_n) ? mem[{prog_data_sel, addr_lo}]
                     : 8'hA5 ^ {8{sys_clk}};
endmodule : msd_ext_mem

// file: test/test_memory_space_decoder.sv
// Purpose: Self-checking bench for msd_decoder
// Assumes: Inputs change on falling edge
// Notes:   Partner model answers external cycles
`timescale 1ns/1ps
module test_memory_space_decoder;
  logic sys_clk, nrst, req, req_prog, req_write, bank_en, done, reserved_err, sel_prog_rom,
    sel_data_ram, address_strobe_n, data_strobe_n, rd_wr_n, prog_data_sel, ad_oe;
  logic [15:0] req_addr;
  logic [7:0] req_wdata, bank_sel, ext_rdata, rdata, ad_out, addr_hi, addr_lo, bank_addr, r;
  logic sawds;
  int err_total = 0, n_compared = 0;
  msd_decoder u_msd_decoder (.*);
  msd_ext_mem u_msd_ext_mem (.*);
  // Clock
  initial begin sys_clk = 0; forever #5 sys_clk = ~sys_clk; end
  task chk(input string n, input logic [7:0] e, s);
    n_compared++;
    if (s !== e) begin err_total++; $display("wrong value %s exp %h got %h", n, e, s); end
  endtask : chk
  // One request, held until done
  task cyc(input logic p, w, input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk); req = 1; req_prog = p; req_write = w; req_addr = a; req_wdata = d;
    sawds = 0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) begin
      @(negedge sys_clk); if (data_strobe_n === 1'b0) sawds = 1;
    end
    chk("done", 1, done);
    chk("rsv flag", 0, reserved_err);
    req = 0; r = rdata;
  endtask : cyc
  task t_onchip;
    cyc(1, 0, 16'h7FFF, 0); chk("rom ds", 0, sawds);
    cyc(0, 1, 16'h04FF, 1); chk("ram ds", 0, sawds);
    $display("t_onchip end");
  endtask : t_onchip
  task t_ext;
    cyc(0, 1, 16'h0500, 8'h5A); chk("ext ds", 1, sawds);
    cyc(0, 0, 16'h0500, 0); chk("data rd", 8'h5A, r);
    cyc(0, 1, 16'hFFFF, 8'h77); cyc(0, 0, 16'hFFFF, 0); chk("top rd", 8'h77, r);
    cyc(1, 0, 16'hFFC0, 0); chk("top prog ds", 1, sawds);
    $display("t_ext end");
  endtask : t_ext
  task t_space;
    bank_en = 1; bank_sel = 8'h3C;
    cyc(1, 1, 16'h8000, 8'hA5); cyc(0, 1, 16'h8000, 8'hC3);
    cyc(1, 0, 16'h8000, 0); chk("prog rd", 8'hA5, r);
    cyc(0, 0, 16'h8000, 0); chk("data rd", 8'hC3, r);
    $display("t_space end");
  endtask : t_space
  task close_out;
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin #20000; err_total++; close_out; end
  initial begin
    nrst = 0; req = 0; req_prog = 0; req_write = 0; req_addr = 0; req_wdata = 0;
    bank_en = 0; bank_sel = 0;
    repeat (8) @(negedge sys_clk);
    nrst = 1;
    t_onchip; t_ext; t_space; close_out;
  end
endmodule : test_memory_space_decoder
bind msd_decoder msd_checker u_msd_checker (.*);
